// >>> bench/alarm_props.sv
// port checker for the alarm sequence block
// assumes it is bound onto alarm_sequence_fsm
`timescale 1ns/10ps
`default_nettype none
module alarm_props #(
  parameter int unsigned NCH = 8
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [NCH-1:0] proc_abn_i,
  input wire logic ack_pb_i,
  input wire logic reset_pb_i,
  input wire logic test_pb_i,
  input wire logic [NCH-1:0] lamp_o,
  input wire logic horn_o,
  input wire logic ring_horn_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence quiet3;
    $stable(proc_abn_i) [*3];
  endsequence
  chk_apb_ready: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  chk_bad_addr: assert property (setup_s ##0 (paddr_i > 8'h0c) |=> pslverr_o && prdata_o == 0)
    else $error("unmapped access not refused");
  chk_good_addr: assert property (setup_s ##0 (paddr_i inside {0, 4, 8, 12}) |=> !pslverr_o)
    else $error("mapped access refused");
  chk_ack_silent: assert property (
    ($rose(ack_pb_i) && $stable(proc_abn_i)) ##1 quiet3 |-> !horn_o)
    else $error("horn on after acknowledge");
  chk_reset_ring: assert property (
    ($rose(reset_pb_i) && proc_abn_i == 0) ##1 (proc_abn_i == 0) [*3] |-> !ring_horn_o)
    else $error("ringback kept after reset");
  chk_test_lamps: assert property (test_pb_i [*2] |-> &lamp_o)
    else $error("lamp test not lit");
  chk_horn_cause: assert property (
    $rose(horn_o) |-> $past(|proc_abn_i) || $past(|proc_abn_i, 2))
    else $error("horn without alarm");
endmodule : alarm_props
`default_nettype wire

// >>> bench/field_model.sv
// field side: process contacts and operator pushbuttons
// assumes levels change just after rising edges of mclk_i
`timescale 1ns/10ps
`default_nettype none
module field_model #(
  parameter int unsigned NCH = 8
) (
  input wire logic mclk_i,
  output var logic [NCH-1:0] proc_abn_o,
  output var logic [4:0] btn_o
);
  initial begin
    proc_abn_o = '0;
    btn_o = '0;
  end
  task automatic set_abn(input int c, input logic v);
    @(posedge mclk_i);
    proc_abn_o[c] <= v;
    repeat (4) @(posedge mclk_i);
  endtask : set_abn
  task automatic set_btn(input int k, input logic v);
    @(posedge mclk_i);
    btn_o[k] <= v;
    repeat (4) @(posedge mclk_i);
  endtask : set_btn
endmodule : field_model
`default_nettype wire

// >>> bench/tb_alarm_sequence_fsm.sv
// self-checking bench for the alarm sequence block
// assumes field_model drives contacts and buttons; apb driven here
`timescale 1ns/10ps
`default_nettype none
module tb_alarm_sequence_fsm;
  localparam int NCH = 8;
  localparam logic [31:0] OFF = 32'h0, ON = 32'h0020_0000, FAST = 32'h0010_0008;
  localparam logic [31:0] SLOW = 32'h0010_0004, INTM = 32'h0008_0004;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, horn_o, ring_horn_o, er;
  logic [NCH-1:0] proc_abn_i, lamp_o;
  logic [4:0] btn;
  int failures = 0;
  int cmp_count = 0;
  always #5 mclk_i = ~mclk_i;
  field_model #(.NCH(NCH)) u_field_model (.mclk_i, .proc_abn_o(proc_abn_i), .btn_o(btn));
  alarm_sequence_fsm #(.NCH(NCH), .FLASH_HALF_CYC(4)) u_alarm_sequence_fsm (
    .mclk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .proc_abn_i, .ack_pb_i(btn[0]), .reset_pb_i(btn[1]),
    .silence_pb_i(btn[2]), .first_reset_pb_i(btn[3]), .test_pb_i(btn[4]), .lamp_o,
    .horn_o, .ring_horn_o);
  task automatic test_done();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o === 1'b1) begin
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end else begin
      failures++;
      test_done();
    end
  endtask : apb
  // lamp signature: lit cycles and toggles over 32 cycles
  task automatic look(input int c, input logic [31:0] lamp_exp, input logic h);
    int lit;
    int tog;
    logic prev;
    lit = 0;
    tog = 0;
    @(posedge mclk_i);
    prev = lamp_o[c];
    for (int i = 0; i < 32; i++) begin
      lit += prev;
      @(posedge mclk_i);
      tog += (lamp_o[c] != prev);
      prev = lamp_o[c];
    end
    chk({lit[15:0], tog[15:0]}, lamp_exp);
    chk({31'h0, horn_o}, {31'h0, h});
  endtask : look
  task automatic ab(input int c, input logic v);
    u_field_model.set_abn(c, v);
  endtask : ab
  task automatic pr(input int k);
    u_field_model.set_btn(k, 1'b1);
    u_field_model.set_btn(k, 1'b0);
  endtask : pr
  // ***************
  // scenarios
  // ***************
  task automatic s_regs();
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h10, 32'h5);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h04, 32'h0000_0fa4);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_0fa4);
  endtask : s_regs
  task automatic s_nonlock();
    ab(0, 1'b1);
    look(0, FAST, 1'b1);
    ab(0, 1'b0);
    look(0, OFF, 1'b0);
    ab(0, 1'b1);
    pr(0);
    look(0, ON, 1'b0);
    ab(0, 1'b0);
    look(0, OFF, 1'b0);
  endtask : s_nonlock
  task automatic s_ring();
    ab(1, 1'b1);
    ab(1, 1'b0);
    look(1, FAST, 1'b1);
    pr(0);
    look(1, SLOW, 1'b0);
    chk({31'h0, ring_horn_o}, 32'h1);
    ab(1, 1'b1);
    look(1, FAST, 1'b1);
    pr(0);
    pr(1);
    look(1, ON, 1'b0);
    ab(1, 1'b0);
    pr(1);
    look(1, OFF, 1'b0);
    chk({31'h0, ring_horn_o}, 32'h0);
  endtask : s_ring
  task automatic s_fman();
    ab(2, 1'b1);
    ab(3, 1'b1);
    look(2, FAST, 1'b1);
    look(3, ON, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_0201);
    pr(2);
    look(2, FAST, 1'b0);
    pr(0);
    look(2, ON, 1'b0);
    ab(2, 1'b0);
    ab(3, 1'b0);
    look(2, ON, 1'b0);
    pr(1);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
  endtask : s_fman
  task automatic s_fauto();
    ab(4, 1'b1);
    ab(5, 1'b1);
    look(4, INTM, 1'b1);
    look(5, FAST, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_0401);
    pr(0);
    look(4, SLOW, 1'b0);
    look(5, ON, 1'b0);
    ab(5, 1'b0);
    ab(4, 1'b0);
    look(5, OFF, 1'b0);
    look(4, SLOW, 1'b0);
    pr(3);
    look(4, OFF, 1'b0);
  endtask : s_fauto
  initial begin
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    s_regs();
    s_nonlock();
    s_ring();
    s_fman();
    s_fauto();
    u_field_model.set_btn(4, 1'b1);
    chk({24'h0, lamp_o}, 32'hff);
    u_field_model.set_btn(4, 1'b0);
    chk({24'h0, lamp_o}, 32'h0);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    test_done();
  end
endmodule : tb_alarm_sequence_fsm
bind alarm_sequence_fsm alarm_props #(.NCH(NCH)) u_alarm_props (
  .mclk_i, .resetn_i, .psel_i, .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
  .proc_abn_i, .ack_pb_i, .reset_pb_i, .test_pb_i, .lamp_o, .horn_o, .ring_horn_o);
`default_nettype wire

// >>> rtl/alarm_pkg.sv
// shared constants, types and register map for the alarm sequence block
// assumes a single 100 MHz clock and an apb register bus

package alarm_pkg;

  // ***************
  // timing
  // ***************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned PHASE_W = 3;
  localparam int unsigned NCH_DEF = 8;

  // ***************
  // register map
  // ***************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ACTIVE = 8'h0c;
  localparam int unsigned CTRL_RING_AUD_BIT = 0;
  localparam int unsigned MODE_FIELD_W = 2;
  localparam int unsigned STATUS_FVALID_BIT = 0;
  localparam int unsigned STATUS_FIDX_LSB = 8;
  localparam logic CTRL_RING_AUD_RESET = 1'b0;

  // ***************
  // types
  // ***************
  typedef enum logic [1:0] {
    SEQ_NONLOCK = 2'h0,
    SEQ_RINGBACK = 2'h1,
    SEQ_FIRST_MAN = 2'h2,
    SEQ_FIRST_AUTO = 2'h3
  } seq_mode_t;

  typedef enum logic [7:0] {
    ST_NORMAL = 8'h01,
    ST_ALARM = 8'h02,
    ST_ACKED = 8'h04,
    ST_RINGBACK = 8'h08,
    ST_FIRST_ALARM = 8'h10,
    ST_SUB_ALARM = 8'h20,
    ST_FIRST_SIL = 8'h40,
    ST_FIRST_ACKED = 8'h80
  } chan_state_t;

endpackage : alarm_pkg

// >>> rtl/alarm_sequence_fsm.sv
// alarm annunciator sequence logic for a group of channels with apb registers
// assumes debounced, clock-synchronous contact and pushbutton levels
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module alarm_sequence_fsm #(
  parameter int unsigned NCH = alarm_pkg::NCH_DEF,
  parameter int unsigned FLASH_HALF_CYC = alarm_pkg::FLASH_HALF_CYC
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NCH-1:0] proc_abn_i,
  input wire logic ack_pb_i,
  input wire logic reset_pb_i,
  input wire logic silence_pb_i,
  input wire logic first_reset_pb_i,
  input wire logic test_pb_i,
  output logic [NCH-1:0] lamp_o,
  output logic horn_o,
  output logic ring_horn_o
);

  localparam int unsigned IDX_W = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int unsigned MODE_W = alarm_pkg::MODE_FIELD_W * NCH;

  // ***************
  // state
  // ***************
  typedef struct packed {
    alarm_pkg::chan_state_t [NCH-1:0] st;
    logic [NCH-1:0] lamp;
    logic horn;
    logic ring;
    logic fvalid;
    logic [IDX_W-1:0] fidx;
    logic ring_aud;
    logic [MODE_W-1:0] mode;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } top_state_t;

  top_state_t r_reg;
  top_state_t r_next;

  // ***************
  // helpers
  // ***************
  function automatic alarm_pkg::seq_mode_t mode_of(input logic [MODE_W-1:0] mv,
                                                   input int i);
    mode_of = alarm_pkg::seq_mode_t'(mv[alarm_pkg::MODE_FIELD_W*i +: 2]);
  endfunction : mode_of

  function automatic logic is_first_up(input alarm_pkg::seq_mode_t m);
    is_first_up = (m == alarm_pkg::SEQ_FIRST_MAN) || (m == alarm_pkg::SEQ_FIRST_AUTO);
  endfunction : is_first_up

  function automatic logic is_first_st(input alarm_pkg::chan_state_t s);
    is_first_st = (s == alarm_pkg::ST_FIRST_ALARM) || (s == alarm_pkg::ST_FIRST_SIL) ||
                  (s == alarm_pkg::ST_FIRST_ACKED);
  endfunction : is_first_st

  // ***************
  // flash source and button edges
  // ***************
  flash_if fl ();

  flash_gen #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_flash (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .fl(fl.src)
  );

  logic [3:0] press;
  logic ack_p;
  logic rst_p;
  logic sil_p;
  logic frst_p;

  pb_edge #(
    .W(4)
  ) u_pb (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .level_i({first_reset_pb_i, silence_pb_i, reset_pb_i, ack_pb_i}),
    .press_o(press)
  );

  assign ack_p = press[0];
  assign rst_p = press[1];
  assign sil_p = press[2];
  assign frst_p = press[3];

  // ***************
  // next state
  // ***************
  always_comb begin
    alarm_pkg::chan_state_t s;
    alarm_pkg::seq_mode_t m;
    logic a;
    logic taken;
    logic [IDX_W-1:0] gidx;
    logic lmp;
    logic [NCH-1:0] act;
    s = alarm_pkg::ST_NORMAL;
    m = alarm_pkg::SEQ_NONLOCK;
    a = 1'b0;
    taken = 1'b0;
    gidx = '0;
    lmp = 1'b0;
    act = '0;
    r_next = r_reg;
    r_next.horn = 1'b0;
    r_next.ring = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      m = mode_of(r_reg.mode, i);
      s = r_reg.st[i];
      a = proc_abn_i[i];
      act[i] = (s != alarm_pkg::ST_NORMAL);
      case (s)
        alarm_pkg::ST_NORMAL: begin
          if (a) begin
            if (is_first_up(m)) begin
              if (!r_reg.fvalid && !taken) begin
                s = alarm_pkg::ST_FIRST_ALARM;
                taken = 1'b1;
                gidx = IDX_W'(i);
              end else begin
                s = alarm_pkg::ST_SUB_ALARM;
              end
            end else begin
              s = alarm_pkg::ST_ALARM;
            end
          end
        end
        alarm_pkg::ST_ALARM: begin
          if (m == alarm_pkg::SEQ_NONLOCK && !a) begin
            s = alarm_pkg::ST_NORMAL;
          end else if (ack_p) begin
            if (a || m != alarm_pkg::SEQ_RINGBACK) begin
              s = alarm_pkg::ST_ACKED;
            end else begin
              s = alarm_pkg::ST_RINGBACK;
            end
          end
        end
        alarm_pkg::ST_ACKED: begin
          case (m)
            alarm_pkg::SEQ_NONLOCK: begin
              if (!a) begin
                s = alarm_pkg::ST_NORMAL;
              end
            end
            alarm_pkg::SEQ_FIRST_AUTO: begin
              if (!a) begin
                s = alarm_pkg::ST_NORMAL;
              end
            end
            alarm_pkg::SEQ_RINGBACK: begin
              if (!a) begin
                s = alarm_pkg::ST_RINGBACK;
              end
            end
            alarm_pkg::SEQ_FIRST_MAN: begin
              if (rst_p && !a) begin
                s = alarm_pkg::ST_NORMAL;
              end
            end
            default: s = alarm_pkg::ST_NORMAL;
          endcase
        end
        alarm_pkg::ST_RINGBACK: begin
          if (m != alarm_pkg::SEQ_RINGBACK) begin
            s = a ? alarm_pkg::ST_ACKED : alarm_pkg::ST_NORMAL;
          end else if (a) begin
            s = alarm_pkg::ST_ALARM;
          end else if (rst_p) begin
            s = alarm_pkg::ST_NORMAL;
          end
        end
        alarm_pkg::ST_FIRST_ALARM, alarm_pkg::ST_FIRST_SIL: begin
          if (ack_p) begin
            if (m == alarm_pkg::SEQ_FIRST_AUTO) begin
              s = alarm_pkg::ST_FIRST_ACKED;
            end else begin
              s = alarm_pkg::ST_ACKED;
            end
          end else if (frst_p && m == alarm_pkg::SEQ_FIRST_AUTO) begin
            s = alarm_pkg::ST_SUB_ALARM;
          end else if (sil_p) begin
            s = alarm_pkg::ST_FIRST_SIL;
          end
        end
        alarm_pkg::ST_SUB_ALARM: begin
          if (ack_p || sil_p) begin
            s = alarm_pkg::ST_ACKED;
          end
        end
        alarm_pkg::ST_FIRST_ACKED: begin
          if (frst_p || m != alarm_pkg::SEQ_FIRST_AUTO) begin
            s = a ? alarm_pkg::ST_ACKED : alarm_pkg::ST_NORMAL;
          end
        end
        default: s = alarm_pkg::ST_NORMAL;
      endcase
      r_next.st[i] = s;
      // lamp pattern from the new state
      case (s)
        alarm_pkg::ST_ALARM: lmp = fl.fast;
        alarm_pkg::ST_ACKED: lmp = 1'b1;
        alarm_pkg::ST_RINGBACK: lmp = fl.slow;
        alarm_pkg::ST_FIRST_ALARM, alarm_pkg::ST_FIRST_SIL: begin
          lmp = (m == alarm_pkg::SEQ_FIRST_AUTO) ? fl.intm : fl.fast;
        end
        alarm_pkg::ST_SUB_ALARM: begin
          lmp = (m == alarm_pkg::SEQ_FIRST_AUTO) ? fl.fast : 1'b1;
        end
        alarm_pkg::ST_FIRST_ACKED: lmp = fl.slow;
        default: lmp = 1'b0;
      endcase
      r_next.lamp[i] = lmp | test_pb_i;
      if (s == alarm_pkg::ST_ALARM || s == alarm_pkg::ST_FIRST_ALARM ||
          s == alarm_pkg::ST_SUB_ALARM) begin
        r_next.horn = 1'b1;
      end
      if (s == alarm_pkg::ST_RINGBACK && r_reg.ring_aud) begin
        r_next.ring = 1'b1;
      end
    end
    // first-out ownership
    if (r_reg.fvalid && !is_first_st(r_next.st[r_reg.fidx])) begin
      r_next.fvalid = 1'b0;
    end
    if (taken) begin
      r_next.fvalid = 1'b1;
      r_next.fidx = gidx;
    end
    // ***************
    // apb slave
    // ***************
    r_next.pready = 1'b0;
    if (psel_i && !penable_i) begin
      r_next.pready = 1'b1;
      r_next.pslverr = 1'b0;
      r_next.prdata = 32'h0;
      case (paddr_i)
        alarm_pkg::ADDR_CTRL: r_next.prdata = 32'(r_reg.ring_aud);
        alarm_pkg::ADDR_MODE: r_next.prdata = 32'(r_reg.mode);
        alarm_pkg::ADDR_STATUS: begin
          r_next.prdata = (32'(r_reg.fvalid) << alarm_pkg::STATUS_FVALID_BIT) |
                          (32'(r_reg.fidx) << alarm_pkg::STATUS_FIDX_LSB);
        end
        alarm_pkg::ADDR_ACTIVE: r_next.prdata = 32'(act);
        default: r_next.pslverr = 1'b1;
      endcase
    end
    if (psel_i && penable_i && r_reg.pready && pwrite_i && !r_reg.pslverr) begin
      case (paddr_i)
        alarm_pkg::ADDR_CTRL: r_next.ring_aud = pwdata_i[alarm_pkg::CTRL_RING_AUD_BIT];
        alarm_pkg::ADDR_MODE: r_next.mode = pwdata_i[MODE_W-1:0];
        default: r_next.ring_aud = r_reg.ring_aud;
      endcase
    end
  end

  // ***************
  // registers
  // ***************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        r_reg.st[i] <= alarm_pkg::ST_NORMAL;
      end
      r_reg.ring_aud <= alarm_pkg::CTRL_RING_AUD_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata_o = r_reg.prdata;
  assign pready_o = r_reg.pready;
  assign pslverr_o = r_reg.pslverr;
  assign lamp_o = r_reg.lamp;
  assign horn_o = r_reg.horn;
  assign ring_horn_o = r_reg.ring;

endmodule : alarm_sequence_fsm

`default_nettype wire

// >>> rtl/flash_gen.sv
// shared divider producing fast, slow and intermittent flash patterns
// assumes mclk_i at the package clock rate
`timescale 1ns/10ps
`default_nettype none

module flash_gen #(
  parameter int unsigned HALF_CYC = alarm_pkg::FLASH_HALF_CYC
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  flash_if.src fl
);

  typedef struct packed {
    logic [31:0] cnt;
    logic [alarm_pkg::PHASE_W-1:0] ph;
  } fg_state_t;

  fg_state_t r_reg;
  fg_state_t r_next;

  always_comb begin
    r_next = r_reg;
    if (r_reg.cnt >= 32'(HALF_CYC - 1)) begin
      r_next.cnt = 32'h0;
      r_next.ph = r_reg.ph + 3'h1;
    end else begin
      r_next.cnt = r_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign fl.fast = r_reg.ph[0];
  assign fl.slow = r_reg.ph[1];
  assign fl.intm = r_reg.ph[0] & ~r_reg.ph[2];

endmodule : flash_gen

`default_nettype wire

// >>> rtl/flash_if.sv
// carrier for the shared flash patterns
// assumes one source and any number of readers in the same clock domain
`timescale 1ns/10ps
`default_nettype none

interface flash_if;
  logic fast;
  logic slow;
  logic intm;
  modport src (output fast, output slow, output intm);
  modport dst (input fast, input slow, input intm);
endinterface : flash_if

`default_nettype wire

// >>> rtl/pb_edge.sv
// turns pushbutton levels into one-cycle press pulses
// assumes inputs synchronous to mclk_i
`timescale 1ns/10ps
`default_nettype none

module pb_edge #(
  parameter int unsigned W = 4
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] level_i,
  output logic [W-1:0] press_o
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] press;
  } pe_state_t;

  pe_state_t r_reg;
  pe_state_t r_next;

  always_comb begin
    r_next.prev = level_i;
    r_next.press = level_i & ~r_reg.prev;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign press_o = r_reg.press;

endmodule : pb_edge

`default_nettype wire
